// ### sysbus_defines.vh
// Purpose: constants for the system bus signaling layer
// Assumes: one core clock, bus clock arrives as a differential pin pair
// Notes: phase ticks stand in for the bus clock quarter points
//
// Notes on behaviour
// (RULE1) non-data bus signals driven and sampled only at bus clock rising edge
// (RULE2) response to a sampled input goes out no earlier than next rising edge
// (RULE3) a driven common-clock value is observed one bus clock later
// (RULE4) internal state updates one clock after sampling, two after driving
// (RULE5) wired-OR inputs need two clocks settling after deassertion
// (RULE6) data bus moves two chunks per bus clock on source strobes
// (RULE7) data launched at bus clock rising edge and at its midpoint
// (RULE8) strobes toggle at quarter and three-quarter points, centred on data
// (RULE9) positive strobe pre-driven before data, then both strobes toggle
// (RULE10) all strobes deasserted after the last chunk is sent
// (RULE11) receiver captures on strobe difference, into core within one cycle
// (RULE12) driver asserts a common-clock data-ready qualifier with data
// (RULE13) system reset puts every agent into a known state; the data driver only freezes, its pins stay as they were
// (RULE14) reset neither invalidates caches nor writes back modified lines
// (RULE15) after reset release fetching starts at the configured reset vector
// (RULE16) platform holds supply-good low until after reset is first asserted
// (RULE17) core clock is bus clock times a ratio fixed at configuration
// (RULE18) strobe data crosses via small buffer, released once qualifier seen
`ifndef SYSBUS_DEFINES_VH
`define SYSBUS_DEFINES_VH
`define WOR_SETTLE_CLKS 2'h2
`define WOR_COUNT 6
`define WOR_BUS_INIT 0
`define WOR_SNOOP_HIT 1
`define WOR_SNOOP_MOD 2
`define WOR_BLOCK_NEXT 3
`define WOR_PURGE_NOT_DONE 4
`define WOR_BUS_ERROR 5
`define RATIO_MIN 8'h04
`define PH_RISE 0
`define PH_QTR 1
`define PH_MID 2
`define PH_3QTR 3
`endif

// ### ss_data_tx.v
// Purpose: source synchronous data driver, two chunks per bus clock
// Assumes: one-hot quarter-point ticks from the phase generator
// Notes: strobes are active low pins with a shared output enable
`timescale 1ns/1ns
`include "sysbus_defines.vh"
module ss_data_tx #(
    parameter DW = 128
) (
    input wire clk,
    input wire resetn,
    input wire [3:0] tick,
    input wire tx_valid,
    input wire [2*DW-1:0] tx_data,
    input wire tx_last,
    output wire tx_ready,
    output reg [DW-1:0] data_out,
    output reg data_oe,
    output reg data_strobe_pos_n,
    output reg data_strobe_neg_n,
    output reg strobe_oe,
    output reg data_valid_qualifier_n,
    output reg qualifier_oe
);
localparam S_IDLE = 4'h1;
localparam S_PRE = 4'h2;
localparam S_SEND = 4'h4;
localparam S_POST = 4'h8;
reg [3:0] state;
reg [DW-1:0] second;
reg last;
wire rise = tick[`PH_RISE];
// chunk pair taken only at a rising edge in pre-drive or while sending a non-last pair
assign tx_ready = rise && ((state == S_PRE) || (state == S_SEND && !last));
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        state <= S_IDLE;
        second <= {DW{1'b0}};
        last <= 1'b0;
        data_out <= {DW{1'b0}};
        data_oe <= 1'b0;
        data_strobe_pos_n <= 1'b1;
        data_strobe_neg_n <= 1'b1;
        strobe_oe <= 1'b0;
        data_valid_qualifier_n <= 1'b1;
        qualifier_oe <= 1'b0;
    end else begin
        case (state)
        S_IDLE: begin
            if (rise && tx_valid) begin
                state <= S_PRE;
                strobe_oe <= 1'b1; // [RULE9]
                data_strobe_pos_n <= 1'b1;
                data_strobe_neg_n <= 1'b1;
            end
        end
        S_PRE, S_SEND: begin
            if (rise) begin
                if (tx_ready && tx_valid) begin
                    state <= S_SEND;
                    data_out <= tx_data[DW-1:0]; // [RULE7] [RULE6]
                    second <= tx_data[2*DW-1:DW];
                    last <= tx_last;
                    data_oe <= 1'b1;
                    data_valid_qualifier_n <= 1'b0; // [RULE12] [RULE1]
                    qualifier_oe <= 1'b1;
                end else begin
                    // source ran dry or last pair went out: wind down
                    state <= S_POST;
                    data_oe <= 1'b0;
                    data_valid_qualifier_n <= 1'b1;
                    data_strobe_pos_n <= 1'b1; // [RULE10]
                    data_strobe_neg_n <= 1'b1;
                end
            end else if (state == S_SEND) begin
                if (tick[`PH_QTR])
                    data_strobe_pos_n <= ~data_strobe_pos_n; // [RULE8]
                if (tick[`PH_MID])
                    data_out <= second; // [RULE7]
                if (tick[`PH_3QTR])
                    data_strobe_neg_n <= ~data_strobe_neg_n; // [RULE8]
            end
        end
        S_POST: begin
            if (rise) begin
                state <= S_IDLE;
                strobe_oe <= 1'b0;
                qualifier_oe <= 1'b0;
                last <= 1'b0;
            end
        end
        default: state <= S_IDLE;
        endcase
    end
end
endmodule // ss_data_tx

// ### ss_data_rx.v
// Purpose: strobe capture and crossing of received data chunks
// Assumes: strobes and data already passed two flip-flops
// Notes: two-entry buffer holds one chunk pair until qualified
`timescale 1ns/1ns
module ss_data_rx #(
    parameter DW = 128
) (
    input wire clk,
    input wire resetn,
    input wire strobe_pos,
    input wire strobe_neg,
    input wire [DW-1:0] data_in,
    input wire qualifier_seen,
    output reg rx_valid,
    output reg [2*DW-1:0] rx_data
);
reg pos_d;
reg neg_d;
reg [DW-1:0] chunk [0:1];
reg [1:0] full;
// a change of either strobe flips their difference
wire pos_edge = strobe_pos ^ pos_d;
wire neg_edge = strobe_neg ^ neg_d;
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        pos_d <= 1'b1;
        neg_d <= 1'b1;
        full <= 2'h0;
        chunk[0] <= {DW{1'b0}};
        chunk[1] <= {DW{1'b0}};
        rx_valid <= 1'b0;
        rx_data <= {2*DW{1'b0}};
    end else begin
        pos_d <= strobe_pos;
        neg_d <= strobe_neg;
        rx_valid <= 1'b0;
        // both strobes moving at once is the post-burst return, not data
        if (pos_edge && !neg_edge) begin
            chunk[0] <= data_in; // [RULE11]
            full[0] <= 1'b1;
        end
        if (neg_edge && !pos_edge) begin
            chunk[1] <= data_in; // [RULE11]
            full[1] <= 1'b1;
        end
        // hold the pair until the common-clock qualifier vouches for it
        if (qualifier_seen && full == 2'h3 && !pos_edge && !neg_edge) begin
            rx_valid <= 1'b1; // [RULE18]
            rx_data <= {chunk[1], chunk[0]};
            full <= 2'h0;
        end
    end
end
endmodule // ss_data_rx

// ### sysbus_phy.v
// Purpose: system bus signaling layer of a bus agent
// Assumes: core clock clk far faster than the bus clock
// Notes: bus clock quarter points come from a core-cycle phase counter
`timescale 1ns/1ns
`include "sysbus_defines.vh"
module sysbus_phy #(
    parameter DW = 128,
    parameter CW = 8,
    parameter AW = 48
) (
    input wire clk,
    input wire resetn,
    input wire bus_clock_pos,
    input wire bus_clock_neg,
    input wire sys_reset_n,
    input wire supply_ok_input,
    input wire [7:0] ratio_strap,
    input wire [AW-1:0] vector_strap,
    input wire [CW-1:0] ctl_in_n,
    input wire [CW-1:0] ctl_req,
    output reg [CW-1:0] ctl_out_n,
    output reg [CW-1:0] ctl_oe,
    output reg [CW-1:0] ctl_state,
    input wire [`WOR_COUNT-1:0] wor_in_n,
    input wire [`WOR_COUNT-1:0] wor_req,
    output wire [`WOR_COUNT-1:0] wor_out_n,
    output reg [`WOR_COUNT-1:0] wor_oe,
    output reg [`WOR_COUNT-1:0] wor_valid,
    output reg [`WOR_COUNT-1:0] wor_state,
    input wire tx_valid,
    input wire [2*DW-1:0] tx_data,
    input wire tx_last,
    output wire tx_ready,
    output wire [DW-1:0] data_out,
    output wire data_oe,
    input wire [DW-1:0] data_in,
    output wire data_strobe_pos_out_n,
    output wire data_strobe_neg_out_n,
    output wire strobe_oe,
    input wire data_strobe_pos_in_n,
    input wire data_strobe_neg_in_n,
    output wire data_valid_qualifier_out_n,
    output wire qualifier_oe,
    input wire data_valid_qualifier_in_n,
    output wire rx_valid,
    output wire [2*DW-1:0] rx_data,
    output reg core_running,
    output reg fetch_start,
    output reg [AW-1:0] fetch_vector,
    input wire fw_invalidate,
    output reg cache_invalidate,
    output reg [7:0] core_ratio,
    output reg ratio_error
);
////////////////////////////////////////////////////////////////////////
// pin synchronisers: every input pin except the straps passes two flip-flops first
reg [1:0] bclk_p_s;
reg [1:0] bclk_n_s;
reg [1:0] rst_s;
reg [1:0] pok_s;
reg [CW-1:0] ctl_s1;
reg [CW-1:0] ctl_s2;
reg [`WOR_COUNT-1:0] wor_s1;
reg [`WOR_COUNT-1:0] wor_s2;
reg [1:0] qual_s;
reg [1:0] stp_s;
reg [1:0] stn_s;
reg [DW-1:0] din_s1;
reg [DW-1:0] din_s2;
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        bclk_p_s <= 2'h0;
        bclk_n_s <= 2'h3;
        rst_s <= 2'h0;
        pok_s <= 2'h0;
        ctl_s1 <= {CW{1'b1}};
        ctl_s2 <= {CW{1'b1}};
        wor_s1 <= {`WOR_COUNT{1'b1}};
        wor_s2 <= {`WOR_COUNT{1'b1}};
        qual_s <= 2'h3;
        stp_s <= 2'h3;
        stn_s <= 2'h3;
        din_s1 <= {DW{1'b0}};
        din_s2 <= {DW{1'b0}};
    end else begin
        bclk_p_s <= {bclk_p_s[0], bus_clock_pos};
        bclk_n_s <= {bclk_n_s[0], bus_clock_neg};
        rst_s <= {rst_s[0], sys_reset_n};
        pok_s <= {pok_s[0], supply_ok_input};
        ctl_s1 <= ctl_in_n;
        ctl_s2 <= ctl_s1;
        wor_s1 <= wor_in_n;
        wor_s2 <= wor_s1;
        qual_s <= {qual_s[0], data_valid_qualifier_in_n};
        stp_s <= {stp_s[0], data_strobe_pos_in_n};
        stn_s <= {stn_s[0], data_strobe_neg_in_n};
        din_s1 <= data_in;
        din_s2 <= din_s1;
    end
end
////////////////////////////////////////////////////////////////////////
// bus clock edge and quarter-point phase ticks
reg bclk_d;
reg [7:0] phase_cnt;
reg [3:0] tick;
// differential pair: rising edge when pos leads neg
wire bclk_now = bclk_p_s[1] & ~bclk_n_s[1];
wire bus_rise = bclk_now & ~bclk_d;
wire [7:0] quarter = {2'h0, core_ratio[7:2]};
wire [7:0] half = {1'b0, core_ratio[7:1]};
wire [7:0] three_q = quarter + half;
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        bclk_d <= 1'b0;
        phase_cnt <= 8'h00;
        tick <= 4'h0;
    end else begin
        bclk_d <= bclk_now;
        // count restarts on every bus rising edge, ticks track the ratio
        phase_cnt <= bus_rise ? 8'h01 : phase_cnt + 8'h01;
        tick[`PH_RISE] <= bus_rise; // [RULE1]
        tick[`PH_QTR] <= !bus_rise && phase_cnt == quarter;
        tick[`PH_MID] <= !bus_rise && phase_cnt == half;
        tick[`PH_3QTR] <= !bus_rise && phase_cnt == three_q;
    end
end
wire edge_tick = tick[`PH_RISE];
////////////////////////////////////////////////////////////////////////
// reset and power sequencing
localparam P_OFF = 3'h1;
localparam P_RESET = 3'h2;
localparam P_RUN = 3'h4;
reg [2:0] pstate;
reg seen_reset;
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        pstate <= P_OFF;
        seen_reset <= 1'b0;
        core_running <= 1'b0;
        fetch_start <= 1'b0;
        fetch_vector <= {AW{1'b0}};
        core_ratio <= `RATIO_MIN;
        ratio_error <= 1'b0;
    end else begin
        fetch_start <= 1'b0;
        case (pstate)
        P_OFF: begin
            if (!rst_s[1])
                seen_reset <= 1'b1;
            // supply-good only counts once reset has been seen [RULE16]
            if (pok_s[1] && seen_reset)
                pstate <= P_RESET;
        end
        P_RESET: begin
            core_running <= 1'b0; // [RULE13]
            if (!pok_s[1]) begin
                pstate <= P_OFF;
                seen_reset <= 1'b0;
            end else if (rst_s[1]) begin
                // straps caught at release, not under the async reset
                pstate <= P_RUN;
                fetch_vector <= vector_strap; // [RULE15]
                fetch_start <= 1'b1;
                core_running <= 1'b1;
                if (ratio_strap < `RATIO_MIN) begin
                    core_ratio <= `RATIO_MIN; // [RULE17]
                    ratio_error <= 1'b1;
                end else begin
                    core_ratio <= ratio_strap; // [RULE17]
                    ratio_error <= 1'b0;
                end
            end
        end
        P_RUN: begin
            if (!pok_s[1]) begin
                pstate <= P_OFF;
                seen_reset <= 1'b0;
                core_running <= 1'b0;
            end else if (!rst_s[1]) begin
                pstate <= P_RESET;
                core_running <= 1'b0;
            end
        end
        default: pstate <= P_OFF;
        endcase
    end
end
// control and wired-OR pins drop in the very clock that core_running falls; the data driver only freezes, its pins stay as they were
wire agent_reset = (pstate != P_RUN) || !rst_s[1] || !pok_s[1];
// caches survive reset; only firmware asks for invalidation
always @(posedge clk or negedge resetn) begin
    if (!resetn)
        cache_invalidate <= 1'b0;
    else
        cache_invalidate <= fw_invalidate && !agent_reset; // [RULE14]
end
////////////////////////////////////////////////////////////////////////
// common-clock control signals
reg [CW-1:0] ctl_req_q;
reg [CW-1:0] ctl_sampled;
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        ctl_req_q <= {CW{1'b0}};
        ctl_out_n <= {CW{1'b1}};
        ctl_oe <= {CW{1'b0}};
        ctl_sampled <= {CW{1'b0}};
        ctl_state <= {CW{1'b0}};
    end else if (agent_reset) begin
        ctl_req_q <= {CW{1'b0}}; // [RULE13]
        ctl_out_n <= {CW{1'b1}};
        ctl_oe <= {CW{1'b0}};
        ctl_sampled <= {CW{1'b0}};
        ctl_state <= {CW{1'b0}};
    end else if (edge_tick) begin
        // request latched on one edge goes out on the next [RULE2]
        ctl_req_q <= ctl_req;
        ctl_out_n <= ~ctl_req_q; // [RULE1]
        ctl_oe <= {CW{1'b1}};
        ctl_sampled <= ~ctl_s2; // [RULE3]
        ctl_state <= ctl_sampled; // [RULE4]
    end
end
////////////////////////////////////////////////////////////////////////
// wired-OR signals: open drain, extra settling on release
assign wor_out_n = {`WOR_COUNT{1'b0}};
genvar g;
generate
for (g = 0; g < `WOR_COUNT; g = g + 1) begin : wor_lane
    reg [1:0] settle;
    reg sampled;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wor_oe[g] <= 1'b0;
            sampled <= 1'b0;
            settle <= 2'h0;
            wor_valid[g] <= 1'b0;
            wor_state[g] <= 1'b0;
        end else if (agent_reset) begin
            wor_oe[g] <= 1'b0; // [RULE13]
            sampled <= 1'b0;
            settle <= 2'h0;
            wor_valid[g] <= 1'b0;
            wor_state[g] <= 1'b0;
        end else if (edge_tick) begin
            wor_oe[g] <= wor_req[g]; // [RULE1]
            sampled <= ~wor_s2[g];
            if (sampled) begin
                settle <= `WOR_SETTLE_CLKS;
                wor_valid[g] <= 1'b1;
                wor_state[g] <= 1'b1; // [RULE4]
            end else if (settle != 2'h0) begin
                // glitchy release: hold asserted until settled [RULE5]
                settle <= settle - 2'h1;
                wor_valid[g] <= 1'b0;
            end else begin
                wor_valid[g] <= 1'b1;
                wor_state[g] <= 1'b0; // [RULE5]
            end
        end
    end
end
endgenerate
////////////////////////////////////////////////////////////////////////
// source synchronous data path
reg qual_seen;
always @(posedge clk or negedge resetn) begin
    if (!resetn)
        qual_seen <= 1'b0;
    else if (agent_reset)
        qual_seen <= 1'b0;
    else if (edge_tick)
        qual_seen <= ~qual_s[1]; // [RULE12] [RULE1]
end
wire [3:0] tx_tick = agent_reset ? 4'h0 : tick;
ss_data_tx #(
    .DW(DW)
) u_tx (
    .clk(clk),
    .resetn(resetn),
    .tick(tx_tick),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last),
    .tx_ready(tx_ready),
    .data_out(data_out),
    .data_oe(data_oe),
    .data_strobe_pos_n(data_strobe_pos_out_n),
    .data_strobe_neg_n(data_strobe_neg_out_n),
    .strobe_oe(strobe_oe),
    .data_valid_qualifier_n(data_valid_qualifier_out_n),
    .qualifier_oe(qualifier_oe)
);
ss_data_rx #(
    .DW(DW)
) u_rx (
    .clk(clk),
    .resetn(resetn),
    .strobe_pos(stp_s[1]),
    .strobe_neg(stn_s[1]),
    .data_in(din_s2),
    .qualifier_seen(qual_seen), // [RULE18]
    .rx_valid(rx_valid),
    .rx_data(rx_data)
);
endmodule // sysbus_phy

// ### sysbus_phy_checker.sv
// Purpose: port-level checks of the system bus signaling layer
// Assumes: bus period of eight core clocks, straps steady while running
// Notes: bound to every sysbus_phy instance
`timescale 1ns/1ns
module sysbus_phy_checker #(
    parameter DW = 128,
    parameter CW = 8,
    parameter AW = 48
) (
    input wire clk,
    input wire resetn,
    input wire [AW-1:0] vector_strap,
    input wire [CW-1:0] ctl_out_n,
    input wire [CW-1:0] ctl_oe,
    input wire [5:0] wor_oe,
    input wire [5:0] wor_valid,
    input wire tx_ready,
    input wire [DW-1:0] data_out,
    input wire data_oe,
    input wire data_strobe_pos_out_n,
    input wire data_strobe_neg_out_n,
    input wire strobe_oe,
    input wire data_valid_qualifier_out_n,
    input wire qualifier_oe,
    input wire core_running,
    input wire fetch_start,
    input wire [AW-1:0] fetch_vector,
    input wire cache_invalidate
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    idle_outputs_a: assert property (
        !core_running |-> ctl_oe == 0 && wor_oe == 0 && !tx_ready
        && !cache_invalidate) else $error("outputs active before run");
    fetch_vector_a: assert property (
        fetch_start |=> core_running && fetch_vector == vector_strap)
        else $error("wrong fetch vector");
    // one pin value per bus clock, eight core clocks
    ctl_hold_a: assert property (
        core_running && $changed(ctl_out_n) |=> $stable(ctl_out_n)[*7])
        else $error("control pin changed inside bus clock");
    wor_settle_a: assert property (
        core_running && $fell(wor_valid[0])
        |=> (!wor_valid[0])[*8] ##7 !wor_valid[0])
        else $error("wired-or settle too short");
    tx_pair_rate_a: assert property (
        tx_ready |=> (!tx_ready)[*7]) else $error("pairs too close");
    data_launch_a: assert property (
        data_oe && $changed(data_out) |=> $stable(data_out)[*3])
        else $error("chunk launched off half period");
    strobe_centre_a: assert property (
        data_oe && ($changed(data_strobe_pos_out_n)
        || $changed(data_strobe_neg_out_n)) |-> $stable(data_out))
        else $error("strobe edge not centred on data");
    pre_drive_a: assert property (
        $rose(data_oe) |-> $past(strobe_oe, 7) && data_strobe_pos_out_n)
        else $error("strobe not pre-driven");
    strobe_release_a: assert property (
        $fell(data_oe) |-> data_strobe_pos_out_n && data_strobe_neg_out_n)
        else $error("strobes left asserted");
    qualifier_data_a: assert property (
        data_oe |-> !data_valid_qualifier_out_n && qualifier_oe)
        else $error("data without qualifier");
endmodule // sysbus_phy_checker
bind sysbus_phy sysbus_phy_checker #(.DW(DW), .CW(CW), .AW(AW))
    sysbus_phy_checker_i (.*);

// ### bus_agent_model.sv
// Purpose: far bus agent, bus clock source and shared pin resolution
// Assumes: terminated pins other than the data lines read high when nobody drives them
// Notes: bus clock runs free at eight core clocks a period
`timescale 1ns/1ns
module bus_agent_model #(
    parameter DW = 128,
    parameter CW = 8
) (
    input wire clk,
    input wire [5:0] agent_wor,
    input wire [CW-1:0] ctl_out_n,
    input wire [CW-1:0] ctl_oe,
    output wire [CW-1:0] ctl_in_n,
    input wire [5:0] wor_oe,
    output wire [5:0] wor_in_n,
    input wire [DW-1:0] data_out,
    input wire data_oe,
    output wire [DW-1:0] data_in,
    input wire data_strobe_pos_out_n,
    input wire data_strobe_neg_out_n,
    input wire strobe_oe,
    output wire data_strobe_pos_in_n,
    output wire data_strobe_neg_in_n,
    input wire data_valid_qualifier_out_n,
    input wire qualifier_oe,
    output wire data_valid_qualifier_in_n,
    output wire bus_clock_pos,
    output wire bus_clock_neg
);
    reg [2:0] phase = 3'h0;
    reg [DW-1:0] last_data = {DW{1'b0}};
    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        phase <= phase + 3'h1;
        if (data_oe) begin
            last_data <= data_out;
        end
    end
    assign bus_clock_pos = ~phase[2];
    assign bus_clock_neg = phase[2];
    // released data lines must not hold the last chunk
    assign data_in = data_oe ? data_out : ~last_data;
    assign ctl_in_n = ctl_out_n | ~ctl_oe;
    // any agent pulling low wins the wire
    assign wor_in_n = ~(wor_oe | agent_wor);
    assign data_strobe_pos_in_n = data_strobe_pos_out_n | ~strobe_oe;
    assign data_strobe_neg_in_n = data_strobe_neg_out_n | ~strobe_oe;
    assign data_valid_qualifier_in_n =
        data_valid_qualifier_out_n | ~qualifier_oe;
endmodule // bus_agent_model

// ### sysbus_phy_test.sv
// Purpose: self-checking bench for the system bus signaling layer
// Assumes: bus period of eight core clocks, ratio strap of eight
// Notes: data pins loop back through the far agent, sent pairs return
`timescale 1ns/1ns
module sysbus_phy_test;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg sys_reset_n = 1'b0;
    reg supply_ok_input = 1'b0;
    reg [7:0] ratio_strap = 8'h08;
    reg [47:0] vector_strap = 48'h0000_0020_0000;
    reg [7:0] ctl_req = 8'h00;
    reg [5:0] wor_req = 6'h00;
    reg [5:0] agent_wor = 6'h00;
    reg tx_valid = 1'b0;
    reg [255:0] tx_data = 256'h0;
    reg tx_last = 1'b0;
    reg fw_invalidate = 1'b0;
    wire bus_clock_pos, bus_clock_neg, tx_ready, data_oe, strobe_oe;
    wire [7:0] ctl_in_n, ctl_out_n, ctl_oe, ctl_state, core_ratio;
    wire [5:0] wor_in_n, wor_oe, wor_valid, wor_state;
    wire [127:0] data_out, data_in;
    wire data_strobe_pos_out_n, data_strobe_neg_out_n;
    wire data_strobe_pos_in_n, data_strobe_neg_in_n;
    wire data_valid_qualifier_out_n, qualifier_oe, data_valid_qualifier_in_n;
    wire rx_valid, core_running, fetch_start, cache_invalidate, ratio_error;
    wire [255:0] rx_data;
    wire [47:0] fetch_vector;
    integer failures = 0;
    integer n_tests = 0;
    integer n_rx = 0;
    integer n;
    reg [255:0] rx_got [0:1];
    localparam [255:0] pair_a = {{4{32'h89ab_cdef}}, {4{32'h0123_4567}}};
    localparam [255:0] pair_b = {{4{32'hfedc_ba98}}, {4{32'h7654_3210}}};
    sysbus_phy sysbus_phy_i (.*, .wor_out_n());
    bus_agent_model bus_agent_model_i (.*);
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            if (n_rx < 2) begin
                rx_got[n_rx] = rx_data;
            end
            n_rx = n_rx + 1;
        end
    end
    task step(input integer k);
        begin
            repeat (k) @(posedge clk);
            #1;
        end
    endtask
    task check(input logic [255:0] seen, input logic [255:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("MISMATCH at %0t: saw %0h expected %0h",
                    $time, seen, exp);
            end
        end
    endtask
    task release_reset;
        begin
            resetn = 1'b1;
            step(3);
            supply_ok_input = 1'b1; // after system reset seen low
            step(3);
            sys_reset_n = 1'b1;
            step(20);
        end
    endtask
    task start_up;
        begin
            check({ctl_oe, data_valid_qualifier_out_n}, 9'h001);
            release_reset;
            check(core_running, 1'b1);
            check(fetch_vector, vector_strap);
            check(core_ratio, 8'h08);
        end
    endtask
    task ctl_latency;
        begin
            ctl_req = 8'h5a;
            n = 0;
            while (ctl_out_n !== 8'ha5 && n < 30) begin
                step(1);
                n = n + 1;
            end
            check(n >= 8, 1'b1);
            check(ctl_out_n, 8'ha5);
            step(12);
            check(ctl_state, 8'h00);
            step(8);
            check(ctl_state, 8'h5a);
        end
    endtask
    task wor_settle;
        begin
            agent_wor = 6'h3f;
            step(24);
            check({wor_valid, wor_state}, 12'hfff);
            agent_wor = 6'h00;
            step(14);
            check(wor_state, 6'h3f);
            step(8);
            check(wor_valid, 6'h00);
            step(26);
            check({wor_valid, wor_state}, 12'hfc0);
            wor_req = 6'h21;
            step(26);
            check({wor_oe, wor_in_n, wor_state}, 18'h217a1);
            wor_req = 6'h00;
        end
    endtask
    task data_burst;
        begin
            tx_data = pair_a;
            tx_valid = 1'b1;
            n = 0;
            while (tx_ready !== 1'b1 && n < 40) begin
                step(1);
                n = n + 1;
            end
            step(1);
            tx_data = pair_b;
            tx_last = 1'b1;
            n = 1;
            while (tx_ready !== 1'b1 && n < 40) begin
                step(1);
                n = n + 1;
            end
            check(n, 8);
            step(1);
            tx_valid = 1'b0;
            tx_last = 1'b0;
            step(40);
            check(n_rx, 2);
            check(rx_got[0], pair_a);
            check(rx_got[1], pair_b);
            check({data_oe, strobe_oe, qualifier_oe}, 3'h0);
        end
    endtask
    task single_pair;
        begin
            tx_data = pair_b;
            tx_valid = 1'b1;
            tx_last = 1'b1;
            n = 0;
            while (tx_ready !== 1'b1 && n < 40) begin
                step(1);
                n = n + 1;
            end
            step(1);
            tx_valid = 1'b0;
            tx_last = 1'b0;
            step(40);
            check(n_rx, 3);
            check(rx_data, pair_b);
            check({data_strobe_pos_out_n, data_strobe_neg_out_n}, 2'h3);
        end
    endtask
    task invalidate;
        begin
            fw_invalidate = 1'b1;
            step(1);
            check(cache_invalidate, 1'b1);
            fw_invalidate = 1'b0;
            step(1);
            check(cache_invalidate, 1'b0);
        end
    endtask
    task second_reset;
        begin
            resetn = 1'b0;
            sys_reset_n = 1'b0;
            supply_ok_input = 1'b0;
            ratio_strap = 8'h02;
            fw_invalidate = 1'b1;
            step(2);
            check({core_running, cache_invalidate, wor_oe}, 8'h00);
            fw_invalidate = 1'b0;
            release_reset;
            check({ratio_error, core_ratio}, 9'h104);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d, mismatches %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    initial begin
        step(12);
        start_up;
        ctl_latency;
        wor_settle;
        data_burst;
        single_pair;
        invalidate;
        second_reset;
        final_report;
    end
    // whole run is some three hundred clocks
    initial begin
        #(40 * 5000);
        failures = failures + 1;
        final_report;
    end
endmodule // sysbus_phy_test
